// ### inc/lpm_defs.svh
// Register indices, field positions, widths and timing constants of the line performance monitor
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define LPM_IDX_GLOBAL_UPDATE 8'h0d
`define LPM_IDX_IRQ_CTRL_STATUS 8'h58
`define LPM_IDX_FRAMING_ERR 8'h59
`define LPM_IDX_FRAME_LOSS_LOW 8'h5a
`define LPM_IDX_FRAME_LOSS_HIGH 8'h5b
`define LPM_IDX_BIT_CRC_LOW 8'h5c
`define LPM_IDX_BIT_CRC_HIGH 8'h5d
`define LPM_IDX_CODE_VIOL_LOW 8'h5e
`define LPM_IDX_CODE_VIOL_HIGH 8'h5f
`define LPM_IDX_MONITOR_CONFIG 8'h70

// ****************************************
// Field positions
// ****************************************
`define LPM_BIT_HOLDING_OVERRUN 0
`define LPM_BIT_TRANSFER_DONE 1
`define LPM_BIT_TRANSFER_IRQ_ENABLE 2
`define LPM_CFG_E1_MODE 0
`define LPM_CFG_ALIGNMENT_CHANGE_SELECT 1
`define LPM_CFG_FAS_WORD_COUNT 2
`define LPM_CFG_NON_ALIGNMENT_FRAME_BIT2_COUNT 3
`define LPM_CFG_EXCESS_ZERO_COUNT_DISABLE 4
`define LPM_CFG_WIDTH 5

// ****************************************
// Counter widths, configuration reset value and chip identifier
// ****************************************
`define LPM_FER_WIDTH 7
`define LPM_OOF_WIDTH 10
`define LPM_BEE_WIDTH 10
`define LPM_LCV_WIDTH 13
`define LPM_CFG_RESET 5'h00
`define LPM_CHIP_ID 8'h5a

// ****************************************
// Timing: latch must land within 3.5 line periods, i.e. by the third line tick
// ****************************************
`define LPM_LATCH_MAX_LINE_PERIODS_X10 35
`define LPM_LATCH_MAX_LINE_TICKS (`LPM_LATCH_MAX_LINE_PERIODS_X10 / 10)

`endif

// ### inc/lpm_pkg.sv
// Types shared by the line performance monitor
package lpm_pkg;
  typedef enum logic {
    LPM_LATCH_IDLE = 1'b0,
    LPM_LATCH_WAIT = 1'b1
  } lpm_latch_state_type;
endpackage

// ### logic/lpm_sat_counter.sv
// Saturating event counter that restarts from the current increment on a latch
module lpm_sat_counter #(
  parameter int WIDTH = 10,
  parameter int INC_WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [INC_WIDTH-1:0] inc,
  input wire logic restart,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic [WIDTH:0] sum;
  localparam logic [WIDTH-1:0] MAX_COUNT = '1;

  always_comb begin
    // Restart takes this cycle's events so none fall between intervals
    if (restart) begin
      sum = {{(WIDTH + 1 - INC_WIDTH){1'b0}}, inc};
    end else begin
      sum = {1'b0, count_r} + {{(WIDTH + 1 - INC_WIDTH){1'b0}}, inc};
    end
    if (sum > {1'b0, MAX_COUNT}) begin
      count_nxt = MAX_COUNT;
    end else begin
      count_nxt = sum[WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
endmodule // lpm_sat_counter

// ### logic/lpm_perf_monitor.sv
// Line performance monitor counters with APB register access and group latch
//
// Local design decision: the APB interface to the registers.
`include "lpm_defs.svh"

module lpm_perf_monitor
  import lpm_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter logic [7:0] CHIP_ID = `LPM_CHIP_ID // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_tick,
  input wire logic out_of_frame,
  input wire logic in_frame,
  input wire logic out_of_crc_multiframe,
  input wire logic t1_framing_bit_err,
  input wire logic e1_fas_bit_err,
  input wire logic e1_fas_word_err,
  input wire logic e1_non_alignment_frame_bit2_zero,
  input wire logic t1_reframe,
  input wire logic alignment_change,
  input wire logic e1_far_end_block_err,
  input wire logic [2:0] t1_bit_err_count,
  input wire logic e1_crc4_err,
  input wire logic bipolar_violation,
  input wire logic excess_zeros,
  output logic irq_out_n
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] idx;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic idx_counter;
  logic idx_mapped;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [`LPM_CFG_WIDTH-1:0] cfg_r, cfg_nxt;
  logic transfer_irq_enable_r, transfer_irq_enable_nxt;
  logic transfer_done_flag_r, transfer_done_flag_nxt;
  logic holding_overrun_flag_r, holding_overrun_flag_nxt;
  logic irq_out_n_r, irq_out_n_nxt;
  lpm_latch_state_type latch_state_r, latch_state_nxt;
  logic latch_req;
  logic do_latch;
  logic e1_mode;
  logic [1:0] fer_inc;
  logic oof_inc;
  logic [2:0] bee_inc;
  logic [1:0] lcv_inc;
  logic [`LPM_FER_WIDTH-1:0] fer_count;
  logic [`LPM_OOF_WIDTH-1:0] oof_count;
  logic [`LPM_BEE_WIDTH-1:0] bee_count;
  logic [`LPM_LCV_WIDTH-1:0] lcv_count;
  logic [`LPM_FER_WIDTH-1:0] fer_hold_r, fer_hold_nxt;
  logic [`LPM_OOF_WIDTH-1:0] oof_hold_r, oof_hold_nxt;
  logic [`LPM_BEE_WIDTH-1:0] bee_hold_r, bee_hold_nxt;
  logic [`LPM_LCV_WIDTH-1:0] lcv_hold_r, lcv_hold_nxt;

  // ****************************************
  // APB decode
  // ****************************************
  assign idx = paddr[9:2];
  assign access_done = psel && penable && pready_r;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign idx_counter = (idx >= `LPM_IDX_FRAMING_ERR) && (idx <= `LPM_IDX_CODE_VIOL_HIGH);
  assign idx_mapped = idx_counter || (idx == `LPM_IDX_IRQ_CTRL_STATUS) ||
                      (idx == `LPM_IDX_GLOBAL_UPDATE) || (idx == `LPM_IDX_MONITOR_CONFIG);

  // One wait state: ready rises in the second access cycle
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !idx_mapped;
    prdata_nxt = prdata_r;
    if (psel && penable && !pready_r && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      case (idx)
        `LPM_IDX_GLOBAL_UPDATE: begin
          prdata_nxt[7:0] = CHIP_ID;
        end
        `LPM_IDX_IRQ_CTRL_STATUS: begin
          prdata_nxt[`LPM_BIT_TRANSFER_IRQ_ENABLE] = transfer_irq_enable_r;
          prdata_nxt[`LPM_BIT_TRANSFER_DONE] = transfer_done_flag_r;
          prdata_nxt[`LPM_BIT_HOLDING_OVERRUN] = holding_overrun_flag_r;
        end
        `LPM_IDX_FRAMING_ERR: begin
          prdata_nxt[`LPM_FER_WIDTH-1:0] = fer_hold_r;
        end
        `LPM_IDX_FRAME_LOSS_LOW: begin
          prdata_nxt[7:0] = oof_hold_r[7:0];
        end
        `LPM_IDX_FRAME_LOSS_HIGH: begin
          prdata_nxt[`LPM_OOF_WIDTH-9:0] = oof_hold_r[`LPM_OOF_WIDTH-1:8];
        end
        `LPM_IDX_BIT_CRC_LOW: begin
          prdata_nxt[7:0] = bee_hold_r[7:0];
        end
        `LPM_IDX_BIT_CRC_HIGH: begin
          prdata_nxt[`LPM_BEE_WIDTH-9:0] = bee_hold_r[`LPM_BEE_WIDTH-1:8];
        end
        `LPM_IDX_CODE_VIOL_LOW: begin
          prdata_nxt[7:0] = lcv_hold_r[7:0];
        end
        `LPM_IDX_CODE_VIOL_HIGH: begin
          prdata_nxt[`LPM_LCV_WIDTH-9:0] = lcv_hold_r[`LPM_LCV_WIDTH-1:8];
        end
        `LPM_IDX_MONITOR_CONFIG: begin
          prdata_nxt[`LPM_CFG_WIDTH-1:0] = cfg_r;
        end
        default: begin
          prdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************
  // Latch request and line-timed transfer
  // ****************************************
  // write access only, data ignored
  assign latch_req = wr_done && (idx_counter || (idx == `LPM_IDX_GLOBAL_UPDATE));

  // Requests wait for the next line tick so the swap lines up with event timing
  always_comb begin
    latch_state_nxt = latch_state_r;
    do_latch = 1'b0;
    case (latch_state_r)
      LPM_LATCH_IDLE: begin
        if (latch_req) begin
          latch_state_nxt = LPM_LATCH_WAIT;
        end
      end
      LPM_LATCH_WAIT: begin
        // first line tick applies the latch
        if (line_tick) begin
          do_latch = 1'b1;
          latch_state_nxt = latch_req ? LPM_LATCH_WAIT : LPM_LATCH_IDLE;
        end
      end
      default: begin
        latch_state_nxt = LPM_LATCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_state_r <= LPM_LATCH_IDLE;
    end else begin
      latch_state_r <= latch_state_nxt;
    end
  end

  // ****************************************
  // Control, flags and interrupt
  // ****************************************
  always_comb begin
    cfg_nxt = cfg_r;
    transfer_irq_enable_nxt = transfer_irq_enable_r;
    transfer_done_flag_nxt = transfer_done_flag_r;
    holding_overrun_flag_nxt = holding_overrun_flag_r;
    if (wr_done && idx == `LPM_IDX_MONITOR_CONFIG) begin
      cfg_nxt = pwdata[`LPM_CFG_WIDTH-1:0];
    end
    if (wr_done && idx == `LPM_IDX_IRQ_CTRL_STATUS) begin
      transfer_irq_enable_nxt = pwdata[`LPM_BIT_TRANSFER_IRQ_ENABLE];
    end
    if (rd_done && idx == `LPM_IDX_IRQ_CTRL_STATUS) begin
      transfer_done_flag_nxt = 1'b0;
      holding_overrun_flag_nxt = 1'b0;
    end
    // set after clear, so a set wins
    if (do_latch) begin
      transfer_done_flag_nxt = 1'b1;
      if (transfer_done_flag_r) begin
        holding_overrun_flag_nxt = 1'b1;
      end
    end
    irq_out_n_nxt = !(transfer_irq_enable_nxt && transfer_done_flag_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `LPM_CFG_RESET;
      transfer_irq_enable_r <= 1'b0;
      transfer_done_flag_r <= 1'b0;
      holding_overrun_flag_r <= 1'b0;
      irq_out_n_r <= 1'b1;
    end else begin
      cfg_r <= cfg_nxt;
      transfer_irq_enable_r <= transfer_irq_enable_nxt;
      transfer_done_flag_r <= transfer_done_flag_nxt;
      holding_overrun_flag_r <= holding_overrun_flag_nxt;
      irq_out_n_r <= irq_out_n_nxt;
    end
  end

  // ****************************************
  // Event qualification
  // ****************************************
  assign e1_mode = cfg_r[`LPM_CFG_E1_MODE];

  always_comb begin
    fer_inc = 2'b00;
    oof_inc = 1'b0;
    bee_inc = 3'b000;
    if (e1_mode) begin
      // suppressed out of frame; bits or words, plus bit 2 option
      if (!out_of_frame) begin
        fer_inc = {1'b0, cfg_r[`LPM_CFG_FAS_WORD_COUNT] ? e1_fas_word_err : e1_fas_bit_err} +
                  {1'b0, cfg_r[`LPM_CFG_NON_ALIGNMENT_FRAME_BIT2_COUNT] && e1_non_alignment_frame_bit2_zero};
      end
      oof_inc = !out_of_frame && e1_far_end_block_err;
      bee_inc = {2'b00, !out_of_crc_multiframe && e1_crc4_err};
    end else begin
      fer_inc = {1'b0, in_frame && t1_framing_bit_err};
      oof_inc = cfg_r[`LPM_CFG_ALIGNMENT_CHANGE_SELECT] ? alignment_change : t1_reframe;
      bee_inc = t1_bit_err_count;
    end
  end

  assign lcv_inc = {1'b0, bipolar_violation} +
                   {1'b0, excess_zeros && !cfg_r[`LPM_CFG_EXCESS_ZERO_COUNT_DISABLE]};

  // ****************************************
  // Counters
  // ****************************************
  // restart with this cycle's events, saturating
  lpm_sat_counter #(.WIDTH(`LPM_FER_WIDTH), .INC_WIDTH(2)) u_fer (
    .pclk(pclk), .presetn(presetn), .inc(fer_inc), .restart(do_latch), .count(fer_count)
  );
  lpm_sat_counter #(.WIDTH(`LPM_OOF_WIDTH), .INC_WIDTH(1)) u_oof (
    .pclk(pclk), .presetn(presetn), .inc(oof_inc), .restart(do_latch), .count(oof_count)
  );
  lpm_sat_counter #(.WIDTH(`LPM_BEE_WIDTH), .INC_WIDTH(3)) u_bee (
    .pclk(pclk), .presetn(presetn), .inc(bee_inc), .restart(do_latch), .count(bee_count)
  );
  lpm_sat_counter #(.WIDTH(`LPM_LCV_WIDTH), .INC_WIDTH(2)) u_lcv (
    .pclk(pclk), .presetn(presetn), .inc(lcv_inc), .restart(do_latch), .count(lcv_count)
  );

  // ****************************************
  // Holding registers
  // ****************************************
  // group copy on the latch cycle
  always_comb begin
    fer_hold_nxt = do_latch ? fer_count : fer_hold_r;
    oof_hold_nxt = do_latch ? oof_count : oof_hold_r;
    bee_hold_nxt = do_latch ? bee_count : bee_hold_r;
    lcv_hold_nxt = do_latch ? lcv_count : lcv_hold_r;
  end

  // data only, no reset value before the first latch
  always_ff @(posedge pclk) begin
    fer_hold_r <= fer_hold_nxt;
    oof_hold_r <= oof_hold_nxt;
    bee_hold_r <= bee_hold_nxt;
    lcv_hold_r <= lcv_hold_nxt;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_out_n = irq_out_n_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [1:0] wait_ticks_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ticks_r <= 2'b00;
    end else if (latch_state_r == LPM_LATCH_IDLE || do_latch) begin
      wait_ticks_r <= 2'b00;
    end else if (line_tick && wait_ticks_r != 2'b11) begin
      wait_ticks_r <= wait_ticks_r + 2'b01;
    end
  end

  sequence s_status_read;
    rd_done && idx == `LPM_IDX_IRQ_CTRL_STATUS;
  endsequence

  // Output register tracks the registered enable and flag in the same cycle
  property p_irq_follows;
    transfer_irq_enable_r && transfer_done_flag_r |-> !irq_out_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

  property p_irq_masked;
    !transfer_irq_enable_r |-> irq_out_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while disabled");

  property p_done_set;
    do_latch |=> transfer_done_flag_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("transfer flag not set");

  property p_done_clear;
    s_status_read ##0 !do_latch |=> !transfer_done_flag_r && !holding_overrun_flag_r;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("flags not cleared by read");

  property p_overrun;
    do_latch && transfer_done_flag_r |=> holding_overrun_flag_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_no_false_overrun;
    !holding_overrun_flag_r && !(do_latch && transfer_done_flag_r) |=> !holding_overrun_flag_r;
  endproperty
  a_no_false_overrun: assert property (p_no_false_overrun) else $error("spurious overrun");

  property p_latch_copies;
    do_latch |=> fer_hold_r == $past(fer_count) && lcv_hold_r == $past(lcv_count);
  endproperty
  a_latch_copies: assert property (p_latch_copies) else $error("holding not loaded");

  property p_request_waits;
    latch_req && latch_state_r == LPM_LATCH_IDLE |=> latch_state_r == LPM_LATCH_WAIT;
  endproperty
  a_request_waits: assert property (p_request_waits) else $error("latch request lost");

  property p_latch_bound;
    wait_ticks_r <= 2'(`LPM_LATCH_MAX_LINE_TICKS - 1);
  endproperty
  a_latch_bound: assert property (p_latch_bound) else $error("latch later than allowed");

  property p_no_loss;
    do_latch |=> lcv_count == 13'($past(lcv_inc));
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("event lost at latch");

  // Framing count is the narrowest, so it is the one checked at its ceiling
  property p_saturate;
    fer_count == '1 && !do_latch |=> fer_count == '1;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped");

  property p_ready_pulse;
    pready_r |=> !pready_r;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
endmodule // lpm_perf_monitor

// ### bench/lpm_event_source.sv
// Event source model standing in for the receive framer and line decoder
module lpm_event_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] tick_div,
  input wire logic [10:0] ev,
  input wire logic [2:0] bits,
  output logic line_tick,
  output logic [9:0] ev_o,
  output logic [2:0] bit_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // ****************************************
  // Recovered line clock
  // ****************************************
  // line tick rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      line_tick <= 1'b0;
    end else begin
      line_tick <= (cnt_r == 4'h0);
      cnt_r <= (cnt_r + 4'h1 >= tick_div) ? 4'h0 : cnt_r + 4'h1;
    end
  end
  assign ev_o = ev[9:0];
  // Bit error count is zero outside its strobe so idle cycles add nothing
  assign bit_cnt = ev[10] ? bits : 3'h0;
endmodule // lpm_event_source

// ### bench/lpm_perf_monitor_tb.sv
// Self-checking testbench of the line performance monitor
`include "lpm_defs.svh"
module lpm_perf_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_tick, irq_out_n;
  logic out_of_frame, in_frame, out_of_crc_multiframe, irq_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] ev_o;
  logic [2:0] bit_cnt, bits;
  logic [10:0] ev;
  logic [3:0] tick_div;
  logic [4:0] cfg;
  logic er;
  int n_mismatch, checks, cyc, e_fer, e_ten, e_bee, e_lcv;
  lpm_event_source src (.pclk(pclk), .presetn(presetn), .tick_div(tick_div), .ev(ev), .bits(bits),
    .line_tick(line_tick), .ev_o(ev_o), .bit_cnt(bit_cnt));
  lpm_perf_monitor DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_tick(line_tick),
    .out_of_frame(out_of_frame), .in_frame(in_frame), .out_of_crc_multiframe(out_of_crc_multiframe),
    .t1_framing_bit_err(ev_o[0]), .e1_fas_bit_err(ev_o[1]), .e1_fas_word_err(ev_o[2]),
    .e1_non_alignment_frame_bit2_zero(ev_o[3]), .t1_reframe(ev_o[4]), .alignment_change(ev_o[5]),
    .e1_far_end_block_err(ev_o[6]), .t1_bit_err_count(bit_cnt), .e1_crc4_err(ev_o[7]),
    .bipolar_violation(ev_o[8]), .excess_zeros(ev_o[9]), .irq_out_n(irq_out_n));
  // ****************************************
  // Clock, timeout and reporting
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask
  // ****************************************
  // Bus cycles and expectations
  // ****************************************
  // Waits on pready only; the slave latency is never assumed
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is seen high; with no limit of its own, only the bench timeout ends it otherwise
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int sat(int v, int w);
    return (v > (1 << w) - 1) ? (1 << w) - 1 : v;
  endfunction
  task automatic note_event(int k, int b);
    logic e1;
    e1 = cfg[0];
    case (k)
      0: e_fer += (!e1 && in_frame);
      1: e_fer += (e1 && !out_of_frame && !cfg[2]);
      2: e_fer += (e1 && !out_of_frame && cfg[2]);
      3: e_fer += (e1 && !out_of_frame && cfg[3]);
      4: e_ten += (!e1 && !cfg[1]);
      5: e_ten += (!e1 && cfg[1]);
      6: e_ten += (e1 && !out_of_frame);
      7: e_bee += (e1 && !out_of_crc_multiframe);
      8: e_lcv += 1;
      9: e_lcv += !cfg[4];
      default: e_bee += e1 ? 0 : b;
    endcase
    e_fer = sat(e_fer, 7);
    e_ten = sat(e_ten, 10);
    e_bee = sat(e_bee, 10);
    e_lcv = sat(e_lcv, 13);
  endtask
  task automatic latch(input logic holding_overrun_flag);
    int n;
    logic [2:0] r;
    r = 3'($urandom_range(7, 0));
    apb(1'b1, (r == 3'h0) ? `LPM_IDX_GLOBAL_UPDATE : 8'h58 + 8'(r), $urandom);
    n = 0;
    while (irq_out_n !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (irq_en) chk1("latch_latency", 1'b1, n <= (35 * tick_div) / 10 + 3);
    repeat (300) @(posedge pclk);
    if (!irq_en) chk1("irq_masked", 1'b1, irq_out_n);
  endtask
  task automatic run_interval(input logic [4:0] c, input int n, input int klo, input int khi, input logic rl);
    int k, b;
    apb(1'b1, `LPM_IDX_MONITOR_CONFIG, {27'h0, c});
    apb(1'b0, `LPM_IDX_MONITOR_CONFIG, 32'h0);
    chk32("config", {27'h0, c}, rd);
    cfg = c;
    @(posedge pclk);
    tick_div <= 4'($urandom_range(7, 1));
    out_of_frame <= rl && ($urandom_range(3, 0) == 0);
    in_frame <= !rl || ($urandom_range(3, 0) != 0);
    out_of_crc_multiframe <= rl && ($urandom_range(3, 0) == 0);
    e_fer = 0;
    e_ten = 0;
    e_bee = 0;
    e_lcv = 0;
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      k = $urandom_range(khi, klo);
      b = $urandom_range(7, 1);
      note_event(k, b);
      ev <= 11'(1 << k);
      bits <= 3'(b);
      @(posedge pclk);
      ev <= 11'h000;
      @(posedge pclk);
    end
    latch(1'b0);
    apb(1'b0, `LPM_IDX_FRAMING_ERR, 32'h0);
    chk32("framing_count", 32'(e_fer), rd);
    apb(1'b0, `LPM_IDX_FRAME_LOSS_LOW, 32'h0);
    chk32("ten_bit_low", 32'(e_ten % 256), rd);
    apb(1'b0, `LPM_IDX_FRAME_LOSS_HIGH, 32'h0);
    chk32("ten_bit_high", 32'(e_ten / 256), rd);
    apb(1'b0, `LPM_IDX_BIT_CRC_LOW, 32'h0);
    chk32("bit_crc_low", 32'(e_bee % 256), rd);
    apb(1'b0, `LPM_IDX_BIT_CRC_HIGH, 32'h0);
    chk32("bit_crc_high", 32'(e_bee / 256), rd);
    apb(1'b0, `LPM_IDX_CODE_VIOL_LOW, 32'h0);
    chk32("code_viol_low", 32'(e_lcv % 256), rd);
    apb(1'b0, `LPM_IDX_CODE_VIOL_HIGH, 32'h0);
    chk32("code_viol_high", 32'(e_lcv / 256), rd);
    apb(1'b0, `LPM_IDX_IRQ_CTRL_STATUS, 32'h0);
    chk32("status", {29'h0, irq_en, 2'b10}, rd);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, irq_en, out_of_frame, out_of_crc_multiframe} = 7'h00;
    in_frame = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 11'h000;
    bits = 3'h0;
    tick_div = 4'h1;
    cfg = 5'h00;
    rd = $urandom(32'h058a6c4f);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LPM_IDX_IRQ_CTRL_STATUS, 32'h0);
    chk32("status_reset", 32'h0, rd);
    apb(1'b0, `LPM_IDX_GLOBAL_UPDATE, 32'h0);
    chk32("chip_id", {24'h0, `LPM_CHIP_ID}, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk32("unmapped_data", 32'h0, rd);
    chk1("unmapped_err", 1'b1, er);
    // Flag bits are read-only, so writing them must not set them
    apb(1'b1, `LPM_IDX_IRQ_CTRL_STATUS, 32'h3);
    run_interval(5'h00, 80, 0, 10, 1'b1);
    run_interval(5'h02, 80, 0, 10, 1'b1);
    run_interval(5'h01, 80, 0, 10, 1'b1);
    run_interval(5'h05, 80, 0, 10, 1'b1);
    run_interval(5'h19, 80, 0, 10, 1'b1);
    run_interval(5'h00, 135, 0, 0, 1'b0);
    run_interval(5'h00, 300, 10, 10, 1'b0);
    irq_en = 1'b1;
    apb(1'b1, `LPM_IDX_IRQ_CTRL_STATUS, 32'h4);
    chk1("irq_idle", 1'b1, irq_out_n);
    latch(1'b0);
    chk1("irq_active", 1'b0, irq_out_n);
    latch(1'b1);
    apb(1'b0, `LPM_IDX_IRQ_CTRL_STATUS, 32'h0);
    chk32("status_overrun", 32'h7, rd);
    @(posedge pclk);
    chk1("irq_acked", 1'b1, irq_out_n);
    apb(1'b0, `LPM_IDX_IRQ_CTRL_STATUS, 32'h0);
    chk32("status_cleared", 32'h4, rd);
    complete_run();
  end
endmodule // lpm_perf_monitor_tb
